/* hw/cpu_decode_map.svh */
// Constants for the addressing decoder and power-mode control
`ifndef CPU_DECODE_MAP_SVH
`define CPU_DECODE_MAP_SVH
`define HI_BTB 4'h0
`define HI_BSC 4'h1
`define HI_REL 4'h2
`define HI_RMW_DIR 4'h3
`define HI_RMW_A 4'h4
`define HI_RMW_X 4'h5
`define HI_RMW_IX1 4'h6
`define HI_RMW_IX 4'h7
`define HI_IMM 4'hA
`define HI_DIR 4'hB
`define HI_EXT 4'hC
`define HI_IX2 4'hD
`define HI_IX1 4'hE
`define HI_IX 4'hF
`define LO_LOAD 4'h6
`define LO_STORE 4'h7
`define LO_TEST 4'hD
`define OP_STOP 8'h8E
`define OP_WAIT 8'h8F
`define REL_ALWAYS 4'h0
`define REL_CARRY_CLR 4'h4
`define REL_CARRY_SET 4'h5
`define RESET_VEC 16'h0000
`define PC_BRANCH_BIAS 16'h0002
`define PAGE_ZERO_HI 8'h00
`define CYC_IMM 4'h2
`define CYC_DIR 4'h3
`define CYC_EXT 4'h4
`define CYC_IX 4'h3
`define CYC_IX1 4'h4
`define CYC_IX2 4'h5
`define CYC_STORE_IX 4'h4
`define CYC_BIT 4'h5
`define CYC_REL 4'h3
`define CYC_RMW_REG 4'h2
`define CYC_RMW_DIR 4'h5
`define CYC_RMW_IX 4'h5
`define CYC_RMW_IX1 4'h6
`define CYC_TST_DIR 4'h4
`define CYC_TST_IX 4'h4
`define CYC_TST_IX1 4'h5
`define CYC_CTRL 4'h2
`define CYC_PWR 4'h4
`endif

/* hw/cpu_decode_pkg.sv */
// Types shared by the decoder, its checker and its bench
package cpu_decode_pkg;
  typedef enum logic [3:0] {
    MODE_IMM, MODE_DIR, MODE_EXT, MODE_REL, MODE_IX, MODE_IX1, MODE_IX2,
    MODE_BSC, MODE_BTB, MODE_IMP
  } addr_mode_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP, PWR_STANDBY} power_mode_t;
endpackage

/* hw/page_zero_ram.sv */
// Page-zero RAM with registered read data
`timescale 1ns/1ps
module page_zero_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic writeEnable,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [DW-1:0] writeData,
  input wire logic [AW-1:0] readAddr,
  output logic [DW-1:0] readData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents survive every power mode; no reset on the array
  always_ff @(posedge clk) begin
    if (writeEnable) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule

/* hw/cpu_addressing_decode.sv */
// Instruction fetch, addressing decode and low-power mode control
`timescale 1ns/1ps
`include "cpu_decode_map.svh"
module cpu_addressing_decode
  import cpu_decode_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic standby_request_n,
  input wire logic reset_in_n,
  input wire logic external_irq,
  input wire logic external_irq_secondary,
  input wire logic timerIrq,
  input wire logic timer2Irq,
  input wire logic serialIrq,
  input wire logic [7:0] progData,
  input wire logic [7:0] indexReg,
  input wire logic carryIn,
  input wire logic [7:0] ioPinIn,
  input wire logic [7:0] ioOutData,
  input wire logic [7:0] ioDirection,
  output logic [15:0] progAddr,
  output logic [15:0] effective_address,
  output addr_mode_t addrMode,
  output logic [3:0] operation,
  output logic [3:0] cycleCount,
  output logic [1:0] instrLength,
  output logic load_accumulator_op,
  output logic store_accumulator_op,
  output logic zero_negative_test_op,
  output logic single_bit_set_op,
  output logic single_bit_clear_op,
  output logic branch_if_bit_high_op,
  output logic branch_if_bit_low_op,
  output logic rmwWriteBack,
  output logic carryOut,
  output logic carryLoad,
  output logic instrDone,
  output logic [7:0] ioPinOut,
  output logic [7:0] ioPinOe,
  output logic [7:0] ioPinSync,
  output power_mode_t powerMode,
  output logic cpuClockRun,
  output logic periphClockRun,
  output logic oscRun
);
  typedef enum {S_FETCH, S_B1, S_B2, S_RD, S_WR, S_HALT} fetch_state_t;

  // Pin synchronisers; first stage feeds only the second
  logic [1:0] stbySync, resSync, irqSync, irq2Sync;
  logic [7:0] ioMeta;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stbySync <= 2'h3; // Idle high, so no false standby follows reset
      resSync <= 2'h0;
      irqSync <= 2'h0;
      irq2Sync <= 2'h0;
      ioMeta <= 8'h00;
      ioPinSync <= 8'h00;
    end else begin
      stbySync <= {stbySync[0], standby_request_n};
      resSync <= {resSync[0], reset_in_n};
      irqSync <= {irqSync[0], external_irq};
      irq2Sync <= {irq2Sync[0], external_irq_secondary};
      ioMeta <= ioPinIn;
      ioPinSync <= ioMeta;
    end
  end
  logic standbyAct, resetAct, extIrqAny;
  assign standbyAct = !stbySync[1];
  assign resetAct = !resSync[1];
  assign extIrqAny = irqSync[1] | irq2Sync[1];

  // Mode decode of an opcode, used for the fetched byte and the held opcode
  function automatic addr_mode_t mode_of(input logic [7:0] op);
    case (op[7:4])
      `HI_BTB: mode_of = MODE_BTB;
      `HI_BSC: mode_of = MODE_BSC;
      `HI_REL: mode_of = MODE_REL;
      `HI_RMW_DIR, `HI_DIR: mode_of = MODE_DIR;
      `HI_RMW_IX1, `HI_IX1: mode_of = MODE_IX1;
      `HI_RMW_IX, `HI_IX: mode_of = MODE_IX;
      `HI_IMM: mode_of = MODE_IMM;
      `HI_EXT: mode_of = MODE_EXT;
      `HI_IX2: mode_of = MODE_IX2;
      default: mode_of = MODE_IMP;
    endcase
  endfunction

  // Byte count per mode
  function automatic logic [1:0] len_of(input addr_mode_t m);
    case (m)
      MODE_EXT, MODE_IX2, MODE_BTB: len_of = 2'h3;
      MODE_IX, MODE_IMP: len_of = 2'h1;
      default: len_of = 2'h2;
    endcase
  endfunction

  // Cycle count per opcode
  function automatic logic [3:0] cyc_of(input logic [7:0] op);
    logic rmw;
    logic tst;
    rmw = (op[7:4] >= `HI_RMW_DIR) && (op[7:4] <= `HI_RMW_IX);
    tst = (op[3:0] == `LO_TEST);
    cyc_of = `CYC_CTRL;
    case (op[7:4])
      `HI_BTB, `HI_BSC: cyc_of = `CYC_BIT;
      `HI_REL: cyc_of = `CYC_REL;
      `HI_IMM: cyc_of = `CYC_IMM;
      `HI_DIR: cyc_of = `CYC_DIR;
      `HI_EXT: cyc_of = `CYC_EXT;
      `HI_IX2: cyc_of = `CYC_IX2;
      `HI_IX1: cyc_of = `CYC_IX1;
      `HI_IX: cyc_of = (op[3:0] == `LO_STORE) ? `CYC_STORE_IX : `CYC_IX;
      `HI_RMW_A, `HI_RMW_X: cyc_of = `CYC_RMW_REG;
      `HI_RMW_DIR: cyc_of = tst ? `CYC_TST_DIR : `CYC_RMW_DIR;
      `HI_RMW_IX: cyc_of = tst ? `CYC_TST_IX : `CYC_RMW_IX;
      `HI_RMW_IX1: cyc_of = tst ? `CYC_TST_IX1 : `CYC_RMW_IX1;
      default: cyc_of = ((op == `OP_STOP) || (op == `OP_WAIT)) ? `CYC_PWR : `CYC_CTRL;
    endcase
    if (rmw) begin
      cyc_of = cyc_of;
    end
  endfunction

  fetch_state_t state, next_state;
  power_mode_t next_powerMode;
  logic [15:0] pc, next_pc, opPc, next_opPc;
  logic [7:0] opcode, next_opcode, byte1, next_byte1;
  logic [15:0] next_ea;
  logic next_carryOut, next_carryLoad, next_done;
  logic next_rmwWriteBack;
  logic ramWe;
  logic [7:0] ramWData, ramRData;
  logic [7:0] ramRAddr;

  page_zero_ram #(.AW(8), .DW(8)) u_ram (
    .clk(clk),
    .writeEnable(ramWe),
    .writeAddr(effective_address[7:0]),
    .writeData(ramWData),
    .readAddr(ramRAddr),
    .readData(ramRData)
  );

  addr_mode_t curMode;
  logic [2:0] bitSel;
  logic bitVal, branchTaken;
  logic relTaken;
  logic [15:0] relOff;
  assign curMode = mode_of(opcode);
  assign bitSel = opcode[3:1];
  assign bitVal = ramRData[bitSel];
  assign relOff = {{8{progData[7]}}, progData};
  // Set polarity on even opcodes, clear polarity on odd
  assign branchTaken = opcode[0] ? !bitVal : bitVal;
  // Only carry is visible here; other flag conditions fall through untaken
  assign relTaken = (opcode[3:0] == `REL_ALWAYS) ||
                    ((opcode[3:0] == `REL_CARRY_CLR) && !carryIn) ||
                    ((opcode[3:0] == `REL_CARRY_SET) && carryIn);
  assign ramRAddr = (state == S_B1) ? progData : effective_address[7:0];

  // Fetch and address sequencing; peripherals not modelled here
  always_comb begin
    next_state = state;
    next_powerMode = powerMode;
    next_pc = pc;
    next_opPc = opPc;
    next_opcode = opcode;
    next_byte1 = byte1;
    next_ea = effective_address;
    next_carryOut = carryOut;
    next_carryLoad = 1'b0;
    next_done = 1'b0;
    next_rmwWriteBack = 1'b0;
    ramWe = 1'b0;
    ramWData = ramRData;
    case (state)
      S_FETCH: begin
        next_opcode = progData;
        next_opPc = pc;
        next_pc = pc + 16'h0001;
        if (len_of(mode_of(progData)) == 2'h1) begin
          // Implied or no-offset: done at fetch
          next_ea = (mode_of(progData) == MODE_IX) ? {8'h00, indexReg} : pc;
          next_done = 1'b1;
          if (progData == `OP_WAIT) begin
            next_powerMode = PWR_WAIT;
            next_state = S_HALT;
          end else if (progData == `OP_STOP) begin
            next_powerMode = PWR_STOP;
            next_state = S_HALT;
          end
        end else begin
          next_state = S_B1;
        end
      end
      S_B1: begin
        next_byte1 = progData;
        next_pc = pc + 16'h0001;
        next_state = S_FETCH;
        next_done = 1'b1;
        case (curMode)
          MODE_IMM: next_ea = pc;
          MODE_DIR: next_ea = {`PAGE_ZERO_HI, progData};
          MODE_IX1: next_ea = {8'h00, indexReg} + {8'h00, progData};
          MODE_REL: begin
            next_ea = opPc + `PC_BRANCH_BIAS + relOff;
            if (relTaken) begin
              next_pc = next_ea;
            end
          end
          MODE_BSC, MODE_BTB: begin
            next_ea = {`PAGE_ZERO_HI, progData};
            next_state = S_RD;
            next_done = 1'b0;
          end
          default: begin
            next_state = S_B2;
            next_done = 1'b0;
          end
        endcase
        if ((curMode == MODE_DIR || curMode == MODE_IX1) &&
            (opcode[7:4] <= `HI_RMW_IX) && (opcode[3:0] != `LO_TEST)) begin
          next_rmwWriteBack = 1'b1;
        end
      end
      S_B2: begin
        next_pc = pc + 16'h0001;
        next_state = S_FETCH;
        next_done = 1'b1;
        if (curMode == MODE_IX2) begin
          next_ea = {byte1, progData} + {8'h00, indexReg};
        end else begin
          next_ea = {byte1, progData};
        end
      end
      S_RD: begin
        if (curMode == MODE_BTB) begin
          // Third byte is the offset; PC already past byte two
          next_carryOut = bitVal;
          next_carryLoad = 1'b1;
          next_pc = branchTaken ? (pc + 16'h0001 + relOff) : (pc + 16'h0001);
          next_state = S_FETCH;
          next_done = 1'b1;
        end else begin
          next_state = S_WR;
        end
      end
      S_WR: begin
        // Whole byte rewritten, only the selected bit differs
        ramWData = ramRData;
        ramWData[bitSel] = !opcode[0];
        ramWe = 1'b1;
        next_state = S_FETCH;
        next_done = 1'b1;
      end
      S_HALT: begin
        // Timer and serial requests wake wait, not stop
        if (powerMode == PWR_WAIT &&
            (extIrqAny || timerIrq || timer2Irq || serialIrq)) begin
          next_powerMode = PWR_RUN;
          next_state = S_FETCH;
        end else if (powerMode == PWR_STOP && extIrqAny) begin
          next_powerMode = PWR_RUN;
          next_state = S_FETCH;
        end
      end
      default: next_state = S_FETCH;
    endcase
    // Standby forces reset state; only a reset leaves it
    if (standbyAct) begin
      next_state = S_HALT;
      next_powerMode = PWR_STANDBY;
      next_pc = `RESET_VEC;
      next_done = 1'b0;
      next_carryLoad = 1'b0;
      next_rmwWriteBack = 1'b0;
      ramWe = 1'b0;
    end else if (resetAct) begin
      next_state = S_FETCH;
      next_powerMode = PWR_RUN;
      next_pc = `RESET_VEC;
      next_done = 1'b0;
      next_carryLoad = 1'b0;
      next_rmwWriteBack = 1'b0;
      ramWe = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_FETCH;
      powerMode <= PWR_RUN;
      pc <= `RESET_VEC;
      opPc <= `RESET_VEC;
      opcode <= 8'h00;
      byte1 <= 8'h00;
      effective_address <= 16'h0000;
      carryOut <= 1'b0;
      carryLoad <= 1'b0;
      instrDone <= 1'b0;
      rmwWriteBack <= 1'b0;
    end else begin
      state <= next_state;
      powerMode <= next_powerMode;
      pc <= next_pc;
      opPc <= next_opPc;
      opcode <= next_opcode;
      byte1 <= next_byte1;
      effective_address <= next_ea;
      carryOut <= next_carryOut;
      carryLoad <= next_carryLoad;
      instrDone <= next_done;
      rmwWriteBack <= next_rmwWriteBack;
    end
  end

  // Program address, then the decoded view of the held opcode
  assign progAddr = pc;
  assign addrMode = curMode;
  assign operation = opcode[3:0];
  assign cycleCount = cyc_of(opcode);
  assign instrLength = len_of(curMode);
  assign load_accumulator_op = (opcode[7:4] >= `HI_IMM) && (opcode[3:0] == `LO_LOAD);
  assign store_accumulator_op = (opcode[7:4] > `HI_IMM) && (opcode[3:0] == `LO_STORE);
  assign zero_negative_test_op = (opcode[7:4] >= `HI_RMW_DIR) &&
                                 (opcode[7:4] <= `HI_RMW_IX) && (opcode[3:0] == `LO_TEST);
  assign single_bit_set_op = (curMode == MODE_BSC) && !opcode[0];
  assign single_bit_clear_op = (curMode == MODE_BSC) && opcode[0];
  assign branch_if_bit_high_op = (curMode == MODE_BTB) && !opcode[0];
  assign branch_if_bit_low_op = (curMode == MODE_BTB) && opcode[0];

  // Floating pins in standby; latched data kept for return
  assign ioPinOut = ioOutData;
  assign ioPinOe = (powerMode == PWR_STANDBY) ? 8'h00 : ioDirection;
  assign cpuClockRun = (powerMode == PWR_RUN);
  assign periphClockRun = (powerMode == PWR_RUN) || (powerMode == PWR_WAIT);
  assign oscRun = periphClockRun;
endmodule

/* verif/prog_mem_model.sv */
// Program memory partner for the addressing decoder
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic [15:0] progAddr,
  output logic [7:0] progData
);
  logic [7:0] mem [0:65535];
  // Unwritten cells hold a one-byte no-operation so a stray fetch stays harmless
  initial begin
    for (int i = 0; i < 65536; i++) begin
      if (mem[i] === 8'hXX) mem[i] = 8'h9D; // Bench may have loaded first
    end
  end
  // Same-cycle answer, as the core expects of its program store
  assign progData = mem[progAddr];
endmodule

/* verif/cpu_addressing_decode_chk.sv */
// Port-level assertions for the addressing decoder
`timescale 1ns/1ps
module cpu_addressing_decode_chk
  import cpu_decode_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic standby_request_n,
  input wire logic [15:0] progAddr,
  input wire logic [15:0] effective_address,
  input wire addr_mode_t addrMode,
  input wire logic [3:0] cycleCount,
  input wire logic [1:0] instrLength,
  input wire logic load_accumulator_op,
  input wire logic store_accumulator_op,
  input wire logic zero_negative_test_op,
  input wire logic branch_if_bit_high_op,
  input wire logic branch_if_bit_low_op,
  input wire logic rmwWriteBack,
  input wire logic carryLoad,
  input wire logic instrDone,
  input wire logic [7:0] ioPinOe,
  input wire power_mode_t powerMode,
  input wire logic cpuClockRun,
  input wire logic periphClockRun,
  input wire logic oscRun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Decode figures must hold in the cycle the address is reported
  AST_LOAD_CYCLES: assert property (
    instrDone && load_accumulator_op |-> cycleCount == (addrMode == MODE_IMM ? 4'h2 :
      addrMode == MODE_EXT || addrMode == MODE_IX1 ? 4'h4 : addrMode == MODE_IX2 ? 4'h5 : 4'h3))
    else $error("load cycle count wrong");
  AST_STORE_FORM: assert property (
    instrDone && store_accumulator_op |-> addrMode != MODE_IMM &&
      (addrMode != MODE_IX || cycleCount == 4'h4))
    else $error("store form or cycle count wrong");
  AST_EXT_LEN: assert property (
    instrDone && addrMode == MODE_EXT |-> instrLength == 2'h3)
    else $error("extended length wrong");
  AST_IX_ONE: assert property (
    instrDone && addrMode == MODE_IX |-> instrLength == 2'h1 && effective_address[15:8] == 8'h00)
    else $error("no-offset index form wrong");
  AST_IX1_REACH: assert property (
    instrDone && addrMode == MODE_IX1 |-> instrLength == 2'h2 && effective_address < 16'h0200)
    else $error("8-bit offset form wrong");
  AST_BIT_CARRY: assert property (
    carryLoad |-> instrDone && (branch_if_bit_high_op || branch_if_bit_low_op) &&
      instrLength == 2'h3)
    else $error("carry loaded outside a bit branch");
  AST_TEST_NO_WRITE: assert property (
    zero_negative_test_op |-> !rmwWriteBack)
    else $error("test instruction wrote back");
  AST_STANDBY_ENTRY: assert property (
    !standby_request_n [*4] |=> powerMode == PWR_STANDBY && !oscRun && !cpuClockRun &&
      !periphClockRun && ioPinOe == 8'h00)
    else $error("standby not entered or pins driven");
  AST_STOP_HALT: assert property (
    powerMode == PWR_STOP |-> !oscRun && !cpuClockRun && !periphClockRun)
    else $error("clock running in stop");
  AST_WAIT_KEEP: assert property (
    powerMode == PWR_WAIT && $past(powerMode) == PWR_WAIT |-> $stable(progAddr) && oscRun &&
      periphClockRun && !cpuClockRun)
    else $error("wait mode state not held");
  // Main scenarios reached
  COV_BIT_LOW: cover property (instrDone && branch_if_bit_low_op);
  COV_WAIT_WAKE: cover property (powerMode == PWR_WAIT ##[1:50] powerMode == PWR_RUN);
  COV_STANDBY: cover property (powerMode == PWR_STANDBY);
  COV_TEST_DONE: cover property (instrDone && zero_negative_test_op);
  COV_RMW_WRITE: cover property (rmwWriteBack);
endmodule
bind cpu_addressing_decode cpu_addressing_decode_chk chk_u (.clk, .arst_n, .standby_request_n,
  .progAddr, .effective_address, .addrMode, .cycleCount, .instrLength, .load_accumulator_op,
  .store_accumulator_op, .zero_negative_test_op, .branch_if_bit_high_op, .branch_if_bit_low_op,
  .rmwWriteBack, .carryLoad, .instrDone, .ioPinOe, .powerMode, .cpuClockRun, .periphClockRun,
  .oscRun);

/* verif/cpu_addressing_decode_bench.sv */
// Self-checking bench for the addressing decoder and power modes
`timescale 1ns/1ps
module cpu_addressing_decode_bench;
  import cpu_decode_pkg::*;
  typedef struct {logic [1:0] len; logic [3:0] cyc; logic [15:0] ea; logic useEa; logic useC;
    logic c;} note_t;
  logic clk, arst_n, standby_request_n, reset_in_n, external_irq, external_irq_secondary;
  logic timerIrq, timer2Irq, serialIrq, carryIn, instrDone, carryOut, cpuClockRun;
  logic periphClockRun, oscRun;
  logic [7:0] progData, indexReg, ioPinIn, ioOutData, ioDirection, ioPinOe;
  logic [15:0] progAddr, effective_address;
  logic [3:0] cycleCount;
  logic [1:0] instrLength;
  logic [2:0] n;
  power_mode_t powerMode;
  note_t q[$];
  note_t cur;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wp = 0;
  int seed = 10;

  cpu_addressing_decode dut_u (.clk, .arst_n, .standby_request_n, .reset_in_n, .external_irq,
    .external_irq_secondary, .timerIrq, .timer2Irq, .serialIrq, .progData, .indexReg, .carryIn,
    .ioPinIn, .ioOutData, .ioDirection, .progAddr, .effective_address, .addrMode(),
    .operation(), .cycleCount, .instrLength, .load_accumulator_op(), .store_accumulator_op(),
    .zero_negative_test_op(), .single_bit_set_op(), .single_bit_clear_op(),
    .branch_if_bit_high_op(), .branch_if_bit_low_op(), .rmwWriteBack(), .carryOut,
    .carryLoad(), .instrDone, .ioPinOut(), .ioPinOe, .ioPinSync(), .powerMode, .cpuClockRun,
    .periphClockRun, .oscRun);
  prog_mem_model progMem (.progAddr, .progData);

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("Error %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Bytes go out high byte first, matching the operand order of the core
  task automatic emit(input logic [39:0] b, input int cnt);
    for (int i = cnt - 1; i >= 0; i--) begin
      progMem.mem[wp] = b[8*i +: 8];
      wp++;
    end
  endtask
  task automatic note(input logic [1:0] len, input logic [3:0] cy, input logic [15:0] ea,
      input logic useEa, input logic useC, input logic c);
    q.push_back('{len, cy, ea, useEa, useC, c});
  endtask
  // Taken branch skips two no-operations; a wrong path retires two extra notes
  task automatic bitBr(input logic [7:0] op, input logic c);
    emit({op, 32'h40029D9D}, 5);
    note(2'h3, 4'h5, 16'h0000, 1'h0, 1'h1, c);
  endtask
  task automatic restart(input logic [7:0] op);
    @(posedge clk);
    reset_in_n <= 1'h0;
    progMem.mem[0] = op;
    repeat (4) @(posedge clk);
    reset_in_n <= 1'h1;
  endtask
  task automatic waitMode(input power_mode_t m, input int lim);
    for (int i = 0; i < lim && powerMode !== m; i++) @(posedge clk);
    check(16'(powerMode), 16'(m));
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // Each completion retires the oldest note; fill bytes past the program find none
  always @(posedge clk) begin
    if (arst_n === 1'h1 && instrDone === 1'h1 && q.size() > 0) begin
      cur = q.pop_front();
      check({12'h000, cycleCount}, {12'h000, cur.cyc});
      check({14'h0000, instrLength}, {14'h0000, cur.len});
      if (cur.useEa) check(effective_address, cur.ea);
      if (cur.useC) check({15'h0000, carryOut}, {15'h0000, cur.c});
    end
  end
  // Program load, reset, instruction stream, then the low-power modes
  initial begin
    {standby_request_n, reset_in_n} = 2'h3;
    {external_irq, external_irq_secondary, timerIrq, timer2Irq, serialIrq, carryIn} = 6'h00;
    {ioPinIn, ioOutData, ioDirection} = {8'h00, 8'hA5, 8'hFF};
    indexReg = 8'($random(seed));
    n = 3'($random(seed));
    arst_n = 1'h0;
    emit(40'hA655, 2);
    note(2'h2, 4'h2, 16'h0000, 1'h0, 1'h0, 1'h0);
    emit(40'hB640, 2);
    note(2'h2, 4'h3, 16'h0040, 1'h1, 1'h0, 1'h0);
    emit(40'hC61234, 3);
    note(2'h3, 4'h4, 16'h1234, 1'h1, 1'h0, 1'h0);
    emit(40'hF6, 1);
    note(2'h1, 4'h3, {8'h00, indexReg}, 1'h1, 1'h0, 1'h0);
    emit(40'hE6FF, 2);
    note(2'h2, 4'h4, 16'h00FF + {8'h00, indexReg}, 1'h1, 1'h0, 1'h0);
    emit(40'hD61200, 3);
    note(2'h3, 4'h5, 16'h1200 + {8'h00, indexReg}, 1'h1, 1'h0, 1'h0);
    emit(40'hF7, 1);
    note(2'h1, 4'h4, {8'h00, indexReg}, 1'h1, 1'h0, 1'h0);
    emit(40'h3D40, 2);
    note(2'h2, 4'h4, 16'h0040, 1'h1, 1'h0, 1'h0);
    emit(40'h3C40, 2);
    note(2'h2, 4'h5, 16'h0040, 1'h1, 1'h0, 1'h0);
    emit(40'hBA41, 2);
    note(2'h2, 4'h3, 16'h0041, 1'h1, 1'h0, 1'h0);
    emit(40'({4'h1, n ^ 3'h1, 1'h0, 8'h40}), 2);
    note(2'h2, 4'h5, 16'h0040, 1'h1, 1'h0, 1'h0);
    emit(40'({4'h1, n, 1'h0, 8'h40}), 2);
    note(2'h2, 4'h5, 16'h0040, 1'h1, 1'h0, 1'h0);
    bitBr({4'h0, n, 1'h0}, 1'h1);
    emit(40'({4'h1, n, 1'h1, 8'h40}), 2);
    note(2'h2, 4'h5, 16'h0040, 1'h1, 1'h0, 1'h0);
    emit(40'({4'h0, n, 1'h0, 16'h4003}), 3);
    note(2'h3, 4'h5, 16'h0000, 1'h0, 1'h1, 1'h0);
    emit(40'hC65A5A, 3);
    note(2'h3, 4'h4, 16'h5A5A, 1'h1, 1'h0, 1'h0);
    bitBr({4'h0, n, 1'h1}, 1'h0);
    bitBr({4'h0, n ^ 3'h1, 1'h0}, 1'h1);
    // Branch-never must fall through; taken it would spin on itself
    emit(40'h21FE, 2);
    note(2'h2, 4'h3, 16'(wp - 2), 1'h1, 1'h0, 1'h0);
    emit(40'h20029D9D, 4);
    note(2'h2, 4'h3, 16'(wp), 1'h1, 1'h0, 1'h0);
    emit(40'hC67788, 3);
    note(2'h3, 4'h4, 16'h7788, 1'h1, 1'h0, 1'h0);
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 500 && q.size() > 0; i++) @(posedge clk);
    check(16'(q.size()), 16'h0000);
    restart(8'h8F);
    waitMode(PWR_WAIT, 40);
    check({13'h0000, oscRun, periphClockRun, cpuClockRun}, 16'h0006);
    @(posedge clk);
    serialIrq <= 1'h1;
    waitMode(PWR_RUN, 10);
    serialIrq <= 1'h0;
    restart(8'h8E);
    waitMode(PWR_STOP, 40);
    timerIrq <= 1'h1;
    repeat (10) @(posedge clk);
    check(16'(powerMode), 16'(PWR_STOP));
    timerIrq <= 1'h0;
    external_irq_secondary <= 1'h1;
    waitMode(PWR_RUN, 10);
    external_irq_secondary <= 1'h0;
    standby_request_n <= 1'h0;
    waitMode(PWR_STANDBY, 10);
    check({ioPinOe, 8'h00}, 16'h0000);
    check(progAddr, 16'h0000);
    standby_request_n <= 1'h1;
    repeat (10) @(posedge clk);
    check(16'(powerMode), 16'(PWR_STANDBY));
    reset_in_n <= 1'h0;
    repeat (4) @(posedge clk);
    reset_in_n <= 1'h1;
    waitMode(PWR_RUN, 10);
    results();
  end
endmodule
